// [hdl/dmsep_port.sv]
// Dual-mode serial memory port: one-way stream and two-way bus slave
//
// Overview of operation
// - Power-up starts in one-way stream mode
// - SCL falling edge enters bus mode permanently
// - Stream one bit per clock rise, MSB first
// - Ninth stream bit period leaves SDA released
// - Stream address increments, wraps 7FH to 00H
// - No stream data before nine init clocks
// - SDA during eight init clocks picks start
// - Bus mode ignores transmit clock except protection
// - SDA changes while SCL high are start/stop
// - SDA fall with SCL high is start
// - SDA rise with SCL high is stop
// - Eight-bit words, ninth clock acknowledged low
// - Address word: class nibble, three ignored bits
// - Eighth address bit selects read or write
// - Match acks; mismatch returns silently to standby
// - Standby at power-up and after stop
// - Page write wraps lower three address bits
// - No acknowledge during internal write cycle
// - Address counter holds last plus one
// - Low transmit clock blocks all writes
module dmsep_port #(
  parameter int unsigned WR_CYCLES = dmsep_pkg::WR_CYCLES_DFLT,
  parameter int unsigned FILT_LEN  = dmsep_pkg::FILT_LEN_DFLT
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // Pins (SDA split into input, output and enable)
  input  wire dmsep_pkg::dmsep_pins_t pins,
  output      logic                sda_out,
  output      logic                sda_oe_n,
  // Status
  output      dmsep_pkg::dmsep_status_t status
);
  import dmsep_pkg::*;

  if (WR_CYCLES < 1 || WR_CYCLES > 24'hffffff) begin : g_bad_wr
    $error("dmsep_port: WR_CYCLES must lie in 1 .. 2**24-1");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  dmsep_pins_t      flt;
  dmsep_pins_t      prev_q;
  dmsep_mode_t      mode_q;
  dmsep_bus_state_t state_q;

  logic [DATA_W-1:0] mem_q [2**ADDR_W];
  logic [DATA_W-1:0] page_buf_q [PAGE_LEN];
  logic [PAGE_LEN-1:0] page_mask_q;

  logic [3:0]        init_cnt_q;
  logic              init_high_q;
  logic [3:0]        sbit_q;
  logic [ADDR_W-1:0] stream_addr_q;
  logic              stream_low_q;

  logic [3:0]        bit_cnt_q;
  logic [DATA_W-1:0] shreg_q;
  logic              ack_q;
  logic              rw_q;
  logic [ADDR_W-1:0] addr_q;
  logic              bus_low_q;
  logic [23:0]       wr_cnt_q;

  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic tclk_rise;
  logic in_bus;
  logic start_det;
  logic stop_det;
  logic wr_busy;
  logic wr_done;
  logic commit;

  // Bit i of a word counted from the most significant end
  function automatic logic msb_bit(input logic [7:0] b,
                                   input logic [3:0] i);
    return b[~i[2:0]];
  endfunction

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  // All three pins are asynchronous to clock, so none is read raw
  dmsep_pin_filter #(
    .N_PINS   (3),
    .FILT_LEN (FILT_LEN),
    .IDLE     (PINS_IDLE)
  ) u_filter (
    .clock (clock),
    .rst   (rst),
    .raw   (pins),
    .clean (flt)
  );

  // Previous filtered levels for edge finding
  always_ff @(posedge clock) begin
    if (rst) begin
      prev_q <= PINS_IDLE;
    end else begin
      prev_q <= flt;
    end
  end

  // Edges and bus conditions
  assign scl_rise  = flt.scl & ~prev_q.scl;
  assign scl_fall  = ~flt.scl & prev_q.scl;
  assign sda_rise  = flt.sda & ~prev_q.sda;
  assign sda_fall  = ~flt.sda & prev_q.sda;
  assign tclk_rise = flt.transmit_only_clock & ~prev_q.transmit_only_clock;
  assign in_bus    = (mode_q == mode_two_way_bus);
  // SCL high in both samples keeps a clock edge from looking like a start
  assign start_det = in_bus & flt.scl & prev_q.scl & sda_fall;
  assign stop_det  = in_bus & flt.scl & prev_q.scl & sda_rise;
  assign wr_busy   = (state_q == st_wr_cycle);
  assign wr_done   = wr_busy & (wr_cnt_q == 24'(WR_CYCLES - 1));
  assign commit    = stop_det & ~wr_busy & (|page_mask_q);

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  // Only reset (power cycle) brings the stream mode back
  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= mode_one_way_stream;
    end else if (!in_bus && scl_fall) begin
      mode_q <= mode_two_way_bus;
    end
  end

  // ----------------------------------------
  // One-way stream
  // ----------------------------------------
  // Driven only on transmit clock rises; idle otherwise
  always_ff @(posedge clock) begin
    if (rst) begin
      init_cnt_q    <= '0;
      init_high_q   <= 1'b1;
      sbit_q        <= '0;
      stream_addr_q <= STREAM_START_LOW;
      stream_low_q  <= 1'b0;
    end else if (in_bus || scl_fall) begin
      stream_low_q <= 1'b0;
    end else if (tclk_rise) begin
      if (init_cnt_q < INIT_CLKS) begin
        // Initialisation: listen only, never drive
        init_cnt_q   <= init_cnt_q + 4'h1;
        stream_low_q <= 1'b0;
        if (init_cnt_q < INIT_SAMPLE_CLKS) begin
          init_high_q <= init_high_q & flt.sda;
        end
        if (init_cnt_q == INIT_CLKS - 4'h1) begin
          stream_addr_q <= init_high_q ? STREAM_START_HIGH
                                       : STREAM_START_LOW;
        end
      end else if (sbit_q < ACK_SLOT) begin
        stream_low_q <= ~msb_bit(mem_q[stream_addr_q], sbit_q);
        sbit_q       <= sbit_q + 4'h1;
      end else begin
        // Ninth period released; address wraps through its own width
        stream_low_q  <= 1'b0;
        sbit_q        <= '0;
        stream_addr_q <= stream_addr_q + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // Two-way bus slave
  // ----------------------------------------
  // The stream clock is not looked at here except as write enable
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q     <= st_standby;
      bit_cnt_q   <= '0;
      shreg_q     <= '0;
      ack_q       <= 1'b0;
      rw_q        <= 1'b0;
      addr_q      <= '0;
      bus_low_q   <= 1'b0;
      page_mask_q <= '0;
      for (int i = 0; i < PAGE_LEN; i++) begin
        page_buf_q[i] <= '0;
      end
    end else if (!in_bus) begin
      state_q   <= st_standby;
      bus_low_q <= 1'b0;
    end else if (wr_busy) begin
      // Inputs are deaf until the write cycle ends
      bus_low_q <= 1'b0;
      if (wr_done) begin
        state_q <= st_standby;
      end
    end else if (stop_det) begin
      bus_low_q   <= 1'b0;
      ack_q       <= 1'b0;
      page_mask_q <= '0;
      state_q     <= commit ? st_wr_cycle : st_standby;
    end else if (start_det) begin
      // Repeated start drops uncommitted page data
      state_q     <= st_dev_addr;
      bit_cnt_q   <= '0;
      ack_q       <= 1'b0;
      bus_low_q   <= 1'b0;
      page_mask_q <= '0;
    end else begin
      case (state_q)
        st_dev_addr, st_word_addr, st_wr_data: begin
          if (scl_rise && bit_cnt_q < ACK_SLOT) begin
            shreg_q   <= {shreg_q[6:0], flt.sda};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && ack_q) begin
            // End of acknowledge slot: release and move on
            ack_q     <= 1'b0;
            bus_low_q <= 1'b0;
            bit_cnt_q <= '0;
            case (state_q)
              st_dev_addr: begin
                if (rw_q) begin
                  state_q   <= st_rd_data;
                  shreg_q   <= mem_q[addr_q];
                  bus_low_q <= ~msb_bit(mem_q[addr_q], 4'h0);
                end else begin
                  state_q <= st_word_addr;
                end
              end
              st_word_addr: state_q <= st_wr_data;
              default:      state_q <= st_wr_data;
            endcase
          end else if (scl_fall && bit_cnt_q == ACK_SLOT) begin
            case (state_q)
              st_dev_addr: begin
                // Bits 3..1 are don't-care
                if (shreg_q[7:4] == DEV_CLASS) begin
                  ack_q     <= 1'b1;
                  bus_low_q <= 1'b1;
                  rw_q      <= shreg_q[0];
                end else begin
                  state_q <= st_standby;
                end
              end
              st_word_addr: begin
                addr_q    <= shreg_q[ADDR_W-1:0];
                ack_q     <= 1'b1;
                bus_low_q <= 1'b1;
              end
              default: begin
                // Protected bytes are acked but never reach the array
                ack_q     <= 1'b1;
                bus_low_q <= 1'b1;
                if (flt.transmit_only_clock) begin
                  page_buf_q[addr_q[PAGE_BITS-1:0]]  <= shreg_q;
                  page_mask_q[addr_q[PAGE_BITS-1:0]] <= 1'b1;
                end
                addr_q[PAGE_BITS-1:0] <= addr_q[PAGE_BITS-1:0] + 3'h1;
              end
            endcase
          end
        end
        st_rd_data: begin
          if (scl_rise) begin
            if (bit_cnt_q < ACK_SLOT) begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (bit_cnt_q == ACK_SLOT) begin
              // Host low means continue; high means back to standby at once
              if (!flt.sda) begin
                bit_cnt_q <= CONT_SLOT;
              end else begin
                state_q <= st_standby;
              end
            end
          end else if (scl_fall) begin
            if (bit_cnt_q < ACK_SLOT) begin
              bus_low_q <= ~msb_bit(shreg_q, bit_cnt_q);
            end else if (bit_cnt_q == ACK_SLOT) begin
              bus_low_q <= 1'b0;
              addr_q    <= addr_q + 7'h01;
            end else begin
              shreg_q   <= mem_q[addr_q];
              bus_low_q <= ~msb_bit(mem_q[addr_q], 4'h0);
              bit_cnt_q <= '0;
            end
          end
        end
        st_standby: begin
          bus_low_q <= 1'b0;
        end
        default: begin
          state_q   <= st_standby;
          bus_low_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Internal write cycle timer
  // ----------------------------------------
  // Fixed worst-case length; no early finish is modelled
  always_ff @(posedge clock) begin
    if (rst || !wr_busy) begin
      wr_cnt_q <= '0;
    end else begin
      wr_cnt_q <= wr_cnt_q + 24'h000001;
    end
  end

  // ----------------------------------------
  // Memory array
  // ----------------------------------------
  // Page row comes from the upper address bits, which never move in a page
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        mem_q[i] <= ERASED;
      end
    end else if (commit) begin
      for (int i = 0; i < PAGE_LEN; i++) begin
        if (page_mask_q[i]) begin
          mem_q[{addr_q[ADDR_W-1:PAGE_BITS], 3'(i)}] <= page_buf_q[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // Open drain: the pin is only ever pulled low, never driven high
  always_ff @(posedge clock) begin
    if (rst) begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
      status   <= '{two_way_bus_mode: 1'b0, standby: 1'b1, write_busy: 1'b0};
    end else begin
      sda_out  <= 1'b0;
      sda_oe_n <= ~(stream_low_q | bus_low_q);
      status   <= '{two_way_bus_mode: in_bus,
                    standby:          (state_q == st_standby),
                    write_busy:       wr_busy};
    end
  end

endmodule

// [hdl/dmsep_pkg.sv]
// Shared constants and types of the dual-mode serial memory port
package dmsep_pkg;

  // ----------------------------------------
  // Memory geometry
  // ----------------------------------------
  localparam int         ADDR_W    = 7;
  localparam int         DATA_W    = 8;
  localparam int         PAGE_BITS = 3;
  localparam int         PAGE_LEN  = 8;
  localparam logic [7:0] ERASED    = 8'hff;

  // ----------------------------------------
  // Word framing
  // ----------------------------------------
  localparam logic [3:0] ACK_SLOT  = 4'h8;  // Ninth bit period of a word
  localparam logic [3:0] CONT_SLOT = 4'h9;  // Host acked, next word due
  localparam logic [3:0] DEV_CLASS = 4'ha;  // Fixed one-zero class pattern

  // ----------------------------------------
  // One-way stream start-up
  // ----------------------------------------
  localparam logic [3:0]        INIT_CLKS         = 4'h9;
  localparam logic [3:0]        INIT_SAMPLE_CLKS  = 4'h8;
  localparam logic [ADDR_W-1:0] STREAM_START_HIGH = 7'h7f;
  localparam logic [ADDR_W-1:0] STREAM_START_LOW  = 7'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int T_WR_MS        = 10;
  localparam int T_WR_NS        = T_WR_MS * 1000000;
  localparam int WR_CYCLES_DFLT = T_WR_NS / CLK_PERIOD_NS;
  localparam int FILT_LEN_DFLT  = 4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {
    mode_one_way_stream,
    mode_two_way_bus
  } dmsep_mode_t;

  typedef enum logic [2:0] {
    st_standby,
    st_dev_addr,
    st_word_addr,
    st_wr_data,
    st_rd_data,
    st_wr_cycle
  } dmsep_bus_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic transmit_only_clock;
  } dmsep_pins_t;

  typedef struct packed {
    logic two_way_bus_mode;
    logic standby;
    logic write_busy;
  } dmsep_status_t;

  localparam dmsep_pins_t PINS_IDLE = 3'h6;  // Lines idle high, clock low

endpackage

// [hdl/dmsep_pin_filter.sv]
// Two-flop synchroniser and glitch filter for a group of pins
module dmsep_pin_filter #(
  parameter int unsigned       N_PINS   = 3,
  parameter int unsigned       FILT_LEN = 4,
  parameter logic [N_PINS-1:0] IDLE     = '0
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Pins
  input  wire logic [N_PINS-1:0] raw,
  output      logic [N_PINS-1:0] clean
);

  localparam int CW = $clog2(FILT_LEN + 1);

  if (FILT_LEN < 1 || N_PINS < 1) begin : g_bad
    $error("dmsep_pin_filter: FILT_LEN and N_PINS must be at least 1");
  end

  logic [N_PINS-1:0] meta_q;
  logic [N_PINS-1:0] sync_q;
  logic [CW-1:0]     cnt_q [N_PINS];

  // ----------------------------------------
  // Synchroniser
  // ----------------------------------------
  // Nothing but the second flop reads meta_q
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_q <= IDLE;
      sync_q <= IDLE;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
    end
  end

  // ----------------------------------------
  // Glitch filter
  // ----------------------------------------
  // A new level must hold FILT_LEN cycles before it is accepted
  always_ff @(posedge clock) begin
    if (rst) begin
      clean <= IDLE;
      for (int p = 0; p < N_PINS; p++) begin
        cnt_q[p] <= '0;
      end
    end else begin
      for (int p = 0; p < N_PINS; p++) begin
        if (sync_q[p] == clean[p]) begin
          cnt_q[p] <= '0;
        end else if (cnt_q[p] == CW'(FILT_LEN - 1)) begin
          clean[p] <= sync_q[p];
          cnt_q[p] <= '0;
        end else begin
          cnt_q[p] <= cnt_q[p] + 1'b1;
        end
      end
    end
  end

endmodule

// [testbench/dmsep_port_properties.sv]
// Concurrent checks on the ports of the dual-mode serial memory port
module dmsep_port_properties #(
  parameter int unsigned WR_CYCLES = 50
) (
  // Clock and reset
  input wire logic                     clock,
  input wire logic                     rst,
  // Pins
  input wire dmsep_pkg::dmsep_pins_t   pins,
  input wire logic                     sda_out,
  input wire logic                     sda_oe_n,
  // Status
  input wire dmsep_pkg::dmsep_status_t status
);
  timeunit 1ns;
  timeprecision 100ps;
  import dmsep_pkg::*;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic        tclk_q;
  logic [3:0]  rises_q;
  logic [31:0] busy_cnt_q;

  // Raw stream clock rises; the device sees them later, never earlier
  always_ff @(posedge clock) begin
    tclk_q <= pins.transmit_only_clock;
    if (rst)
      rises_q <= 4'h0;
    else if (pins.transmit_only_clock && !tclk_q && rises_q != 4'hf)
      rises_q <= rises_q + 4'h1;
  end

  // Length of the current write cycle
  always_ff @(posedge clock) begin
    if (rst || !status.write_busy)
      busy_cnt_q <= 32'h0;
    else
      busy_cnt_q <= busy_cnt_q + 32'h1;
  end

  sequence init_phase_s;
    !status.two_way_bus_mode && rises_q < 4'ha;
  endsequence
  sequence switch_s;
    $fell(pins.scl) && !status.two_way_bus_mode;
  endsequence
  sequence stop_s;
    status.two_way_bus_mode && !status.write_busy && pins.scl && $past(pins.scl) && $rose(pins.sda);
  endsequence
  sequence busy_end_s;
    $fell(status.write_busy);
  endsequence

  reset_state_a: assert property (disable iff (1'b0) rst |=> status == 3'h2 && sda_oe_n && !sda_out)
    else $error("outputs not at reset values");
  stream_standby_a: assert property (!status.two_way_bus_mode |-> status.standby && !status.write_busy)
    else $error("stream mode left standby");
  init_silent_a: assert property (init_phase_s |-> sda_oe_n)
    else $error("data driven during initialisation");
  mode_switch_a: assert property (switch_s |-> ##[1:16] status.two_way_bus_mode)
    else $error("clock fall did not enter bus mode");
  mode_sticky_a: assert property (status.two_way_bus_mode |=> status.two_way_bus_mode)
    else $error("bus mode left without reset");
  switch_release_a: assert property ($rose(status.two_way_bus_mode) |-> ##[0:8] sda_oe_n)
    else $error("data line held after mode switch");
  scl_low_change_a: assert property (status.two_way_bus_mode && $changed(sda_oe_n) |-> !pins.scl)
    else $error("data changed with clock high");
  busy_quiet_a: assert property (status.write_busy |-> sda_oe_n)
    else $error("acknowledge during write cycle");
  busy_length_a: assert property (busy_end_s |-> busy_cnt_q == WR_CYCLES)
    else $error("write cycle length wrong");
  busy_standby_a: assert property (busy_end_s |-> ##[0:2] status.standby)
    else $error("no standby after write cycle");
  stop_standby_a: assert property (stop_s |-> ##[1:16] (status.standby || status.write_busy))
    else $error("no standby after stop");
endmodule

// [testbench/dmsep_host.sv]
// Behavioural display host driving both serial links
module dmsep_host (
  // Clock
  input  wire logic clock,
  // Wire
  input  wire logic sda,
  output      logic scl,
  output      logic sda_low,
  output      logic tclk
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PH = 20;  // Cycles per line phase, well past the input filter

  // Lines released and stream clock parked low outside frames
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
    tclk    = 1'b0;
  end

  // One line phase; callers move only one line at a time
  task automatic step(input logic c, input logic d);
    scl     = c;
    sda_low = d;
    repeat (PH) @(posedge clock);
    #1;
  endtask

  // Stream clocks at 125 ns, counting low samples once data is due
  task automatic stream(input int n, input logic init_low, output int lows);
    lows = 0;
    for (int k = 1; k <= n; k++) begin
      sda_low = init_low && k <= 8;
      #62.5;
      // An unknown level counts as driven, so it cannot slip through
      if (k >= 10 && sda !== 1'b1)
        lows++;
      tclk = 1'b1;
      #62.5;
      tclk = 1'b0;
    end
    @(posedge clock);
    #1;
  endtask

  // Nine bits each way; data moves only while the clock is low
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      step(1'b0, !o[k]);
      step(1'b1, !o[k]);
      i[k] = sda;
      step(1'b0, !o[k]);
    end
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic [8:0] r;
    xfer({b, 1'b1}, r);
    ack = !r[0];
  endtask

  task automatic recv_byte(output logic [7:0] b, input logic ack);
    logic [8:0] r;
    xfer({8'hff, !ack}, r);
    b = r[8:1];
  endtask

  task automatic start();
    step(scl, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask

  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask

  // Clock out a stuck transfer until the data line floats high
  task automatic recover(output logic ok);
    ok = 1'b0;
    step(1'b0, 1'b0);
    for (int k = 0; k < 9 && !ok; k++) begin
      step(1'b1, 1'b0);
      ok = sda;
      if (!ok)
        step(1'b0, 1'b0);
    end
  endtask
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the dual-mode serial memory port
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dmsep_pkg::*;
  localparam int unsigned WR_CYC = 700;  // Just outlasts one polled address word

  logic          clock;
  logic          rst;
  logic          scl;
  logic          sda_low;
  logic          tclk;
  logic          sda_out;
  logic          sda_oe_n;
  wire logic     sda;
  dmsep_pins_t   pins;
  dmsep_status_t status;
  logic [7:0]    exp_mem [128];
  logic [7:0]    rnd;
  int            err_count;
  int            cmp_count;

  // Open-drain data wire with pull-up
  assign sda  = !((!sda_oe_n && !sda_out) || sda_low);
  assign pins = '{scl: scl, sda: sda, transmit_only_clock: tclk};

  dmsep_port #(.WR_CYCLES(WR_CYC), .FILT_LEN(FILT_LEN_DFLT)) i_dmsep_port (.clock(clock), .rst(rst),
    .pins(pins), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .status(status));
  dmsep_host i_dmsep_host (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low), .tclk(tclk));

  // 100 MHz system clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Reset also erases the whole array
  task automatic do_reset();
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    rst = 1'b0;
    foreach (exp_mem[a])
      exp_mem[a] = ERASED;
  endtask

  // Bounded wait for the write cycle flag; a timeout ends the run
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 3 * WR_CYC && status.write_busy !== lvl; n++) begin
      @(posedge clock);
      #1;
    end
    chk("write busy", {7'h0, lvl}, {7'h0, status.write_busy});
    if (status.write_busy !== lvl)
      results();
  endtask

  task automatic send_chk(input logic [7:0] b, input logic exp_ack);
    logic ack;
    i_dmsep_host.send_byte(b, ack);
    chk("ack", {7'h0, exp_ack}, {7'h0, ack});
  endtask

  // Start and device address with random ignored bits
  task automatic head(input logic rd);
    rnd = lfsr(rnd);
    i_dmsep_host.start();
    send_chk({DEV_CLASS, rnd[2:0], rd}, 1'b1);
  endtask

  task automatic wr_seq(input logic [6:0] a, input int n);
    head(1'b0);
    send_chk({1'b0, a}, 1'b1);
    for (int k = 0; k < n; k++) begin
      rnd = lfsr(rnd);
      send_chk(rnd, 1'b1);
      if (tclk)
        exp_mem[{a[6:3], 3'(a[2:0] + k)}] = rnd;
    end
    i_dmsep_host.stop();
  endtask

  task automatic rd_seq(input logic [6:0] a, input int n);
    logic [7:0] b;
    head(1'b0);
    send_chk({1'b0, a}, 1'b1);
    head(1'b1);
    for (int k = 0; k < n; k++) begin
      i_dmsep_host.recv_byte(b, k < n - 1);
      chk("read data", exp_mem[7'(a + k)], b);
    end
    i_dmsep_host.stop();
  endtask

  initial begin
    int         lows;
    logic       ok;
    logic [7:0] b;
    logic [6:0] base;
    rst = 1'b1;
    rnd = 8'h41;
    err_count = 0;
    cmp_count = 0;
    do_reset();
    // Stream with the data line high: starts at 7f and wraps to 00
    i_dmsep_host.stream(30, 1'b0, lows);
    chk("stream low bits", 8'h0, 8'(lows));
    chk("bus mode", 8'h0, {7'h0, status.two_way_bus_mode});
    $display("test stream done");
    // Data line low during start-up, then the clock fall into bus mode
    do_reset();
    i_dmsep_host.stream(20, 1'b1, lows);
    chk("stream low bits", 8'h0, 8'(lows));
    i_dmsep_host.step(1'b0, 1'b0);
    chk("bus mode", 8'h1, {7'h0, status.two_way_bus_mode});
    i_dmsep_host.stream(20, 1'b0, lows);
    chk("ignored stream", 8'h0, 8'(lows));
    $display("test mode switch done");
    // Ten bytes into one page, polled while busy, read back
    i_dmsep_host.tclk = 1'b1;
    rnd = lfsr(rnd);
    base = rnd[6:0];
    wr_seq(base, 10);
    wait_busy(1'b1);
    i_dmsep_host.start();
    send_chk({DEV_CLASS, 4'h0}, 1'b0);
    wait_busy(1'b0);
    i_dmsep_host.stop();
    rd_seq({base[6:3], 3'h0}, 8);
    head(1'b1);
    i_dmsep_host.recv_byte(b, 1'b0);
    chk("current read", exp_mem[7'({base[6:3], 3'h0} + 8)], b);
    i_dmsep_host.stop();
    $display("test page write done");
    // Protected write, then a read across the top of memory
    i_dmsep_host.tclk = 1'b0;
    wr_seq(7'h7f, 1);
    wait_busy(1'b0);
    i_dmsep_host.tclk = 1'b1;
    rd_seq(7'h7e, 3);
    $display("test protection done");
    // Foreign class code, then a cut-short read and recovery
    rnd = lfsr(rnd);
    i_dmsep_host.start();
    send_chk({~DEV_CLASS, rnd[3:0]}, 1'b0);
    i_dmsep_host.stop();
    chk("standby", 8'h1, {7'h0, status.standby});
    head(1'b1);
    i_dmsep_host.recv_byte(b, 1'b1);
    chk("current read", exp_mem[7'h01], b);
    i_dmsep_host.recover(ok);
    chk("recovered", 8'h1, {7'h0, ok});
    i_dmsep_host.start();
    i_dmsep_host.stop();
    chk("standby", 8'h1, {7'h0, status.standby});
    $display("test recovery done");
    results();
  end
endmodule

bind dmsep_port dmsep_port_properties #(.WR_CYCLES(WR_CYCLES)) i_dmsep_port_properties (.clock(clock), .rst(rst),
  .pins(pins), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .status(status));
